/* File: core/tick_pkg.sv */
// Shared constants and types for the core tick timer
`default_nettype none
package tick_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CNT_W       = 24;
    localparam int DATA_W      = 32;
    localparam int ADDR_W      = 12;
    localparam int SYNC_STAGES = 3;

    // ************************************************************
    // Register offsets from system_control_space_base
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_RELOAD_VALUE   = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_CURRENT_VALUE  = 12'h018;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int BIT_ENABLE     = 0;
    localparam int BIT_TICK_INT   = 1;
    localparam int BIT_CLOCK_SEL  = 2;
    localparam int BIT_ZERO_FLAG  = 16;

    localparam logic [DATA_W-1:0] CSR_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 24'h00_0000;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 24'h00_0001;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic clockSel;
        logic tickIntEn;
        logic enable;
    } csr_ctrl_s;

    localparam csr_ctrl_s CTRL_RESET = 3'h0;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_CONTROL_STATUS,
        SEL_RELOAD_VALUE,
        SEL_CURRENT_VALUE
    } reg_sel_e;

    function automatic reg_sel_e decodeReg(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr == OFS_CONTROL_STATUS) begin
            sel = SEL_CONTROL_STATUS;
        end else if (addr == OFS_RELOAD_VALUE) begin
            sel = SEL_RELOAD_VALUE;
        end else if (addr == OFS_CURRENT_VALUE) begin
            sel = SEL_CURRENT_VALUE;
        end
        return sel;
    endfunction
endpackage
`default_nettype wire

/* File: core/ref_clock_sync.sv */
// Synchroniser and rising-edge detector for the external reference clock pin
`timescale 1ns/1ps
`default_nettype none
module ref_clock_sync
    import tick_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Pin
    input  wire logic refClkPin,
    // Tick out
    output logic      refTick
);
    logic [SYNC_STAGES-1:0] syncChain_r;
    logic [SYNC_STAGES-1:0] syncChain_nxt;
    logic                   stable_r;
    logic                   stable_nxt;
    logic                   refTick_r;
    logic                   refTick_nxt;

    // ************************************************************
    // Next state
    // ************************************************************
    // Only the last two stages are compared, the first one feeds stage two alone
    always_comb begin
        syncChain_nxt = {syncChain_r[SYNC_STAGES-2:0], refClkPin};
        stable_nxt    = stable_r;
        refTick_nxt   = 1'b0;
        if (syncChain_r[1] == syncChain_r[2]) begin
            stable_nxt  = syncChain_r[2];
            refTick_nxt = syncChain_r[2] && !stable_r;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncChain_r <= '0;
            stable_r    <= 1'b0;
            refTick_r   <= 1'b0;
        end else begin
            syncChain_r <= syncChain_nxt;
            stable_r    <= stable_nxt;
            refTick_r   <= refTick_nxt;
        end
    end

    assign refTick = refTick_r;
endmodule
`default_nettype wire

/* File: core/system_tick_timer.sv */
// Core tick timer: 24-bit down counter with reload, sticky zero flag, APB slave
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Counter is 24 bits, decrementing; any write to current value forces zero.
// [R2] While enabled, counter decrements by one per timer clock until zero.
// [R3] On the timer clock after zero, reload value is loaded, then decrement resumes.
// [R4] Zero-reached flag sets whenever counting moves the counter to zero.
// [R5] Reading control/status clears the zero-reached flag.
// [R6] Current and reload registers are not reset; contents undefined until written.
// [R7] Software should clear current value before enabling the timer.
// [R8] Reload value zero keeps counter at zero, stopping it while enabled.
// [R9] Control/status at 0x10 resets to zero; reload 0x14; current value 0x18.
// [R10] Control bit 0 enables continuous multi-shot counting; clear stops it.
// [R11] Control bit 1 pends tick exception on count to zero, never on write.
// [R12] Control bit 2 selects clock: zero external reference, one core clock.
// [R13] Zero flag reads at bit 16; a current-value write clears it.
module system_tick_timer
    import tick_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // External reference clock pin
    input  wire logic              refClkPin,
    // Tick exception pend request
    output logic                   tickPending
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic              refTick;
    logic              pready_r;
    logic              pready_nxt;
    logic              pslverr_r;
    logic              pslverr_nxt;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] prdata_nxt;
    csr_ctrl_s         ctrl_r;
    csr_ctrl_s         ctrl_nxt;
    logic              zeroFlag_r;
    logic              zeroFlag_nxt;
    logic              tickPending_r;
    logic              tickPending_nxt;
    logic              cntKnown_r;
    logic              cntKnown_nxt;
    logic [CNT_W-1:0]  current_r;
    logic [CNT_W-1:0]  current_nxt;
    logic [CNT_W-1:0]  reload_r;
    logic [CNT_W-1:0]  reload_nxt;
    reg_sel_e          sel;
    logic              setupPhase;
    logic              accessDone;
    logic              wrCsr;
    logic              wrReload;
    logic              wrCurrent;
    logic              rdCsr;
    logic              countTick;
    logic              reachZero;

    ref_clock_sync u_ref_sync (
        .clk       (clk),
        .reset_n   (reset_n),
        .refClkPin (refClkPin),
        .refTick   (refTick)
    );

    // ************************************************************
    // APB decode
    // ************************************************************
    // No wait state: pready rises in the first access cycle
    assign sel        = decodeReg(paddr);
    assign setupPhase = psel && !penable && !pready_r;
    assign accessDone = psel && penable && pready_r;
    assign wrCsr      = accessDone && pwrite && (sel == SEL_CONTROL_STATUS);
    assign wrReload   = accessDone && pwrite && (sel == SEL_RELOAD_VALUE);
    assign wrCurrent  = accessDone && pwrite && (sel == SEL_CURRENT_VALUE);
    assign rdCsr      = accessDone && !pwrite && (sel == SEL_CONTROL_STATUS);

    always_comb begin
        pready_nxt  = setupPhase;
        pslverr_nxt = setupPhase && (sel == SEL_NONE);
        prdata_nxt  = prdata_r;
        if (setupPhase && !pwrite) begin
            prdata_nxt = DATA_ZERO;
            unique case (sel)
                SEL_CONTROL_STATUS: begin
                    prdata_nxt[BIT_ENABLE]    = ctrl_r.enable;
                    prdata_nxt[BIT_TICK_INT]  = ctrl_r.tickIntEn;
                    prdata_nxt[BIT_CLOCK_SEL] = ctrl_r.clockSel;
                    prdata_nxt[BIT_ZERO_FLAG] = zeroFlag_r; // [R13]
                end
                SEL_RELOAD_VALUE: begin
                    prdata_nxt = DATA_W'(reload_r); // [R9]
                end
                SEL_CURRENT_VALUE: begin
                    prdata_nxt = DATA_W'(current_r);
                end
                SEL_NONE: begin
                    prdata_nxt = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= DATA_ZERO;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // ************************************************************
    // Control, flag and pend
    // ************************************************************
    assign countTick = ctrl_r.enable && (ctrl_r.clockSel || refTick); // [R10] [R12]
    // A software write to current value wins, so it never counts as reaching zero
    assign reachZero = countTick && !wrCurrent && (current_r == CNT_ONE); // [R4] [R11]

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wrCsr) begin
            ctrl_nxt.enable    = pwdata[BIT_ENABLE];
            ctrl_nxt.tickIntEn = pwdata[BIT_TICK_INT];
            ctrl_nxt.clockSel  = pwdata[BIT_CLOCK_SEL];
        end
        // Clear only what the read returned, so a set between setup and access survives
        zeroFlag_nxt = zeroFlag_r;
        if ((rdCsr && prdata_r[BIT_ZERO_FLAG]) || wrCurrent) begin
            zeroFlag_nxt = 1'b0; // [R5] [R13]
        end
        if (reachZero) begin
            zeroFlag_nxt = 1'b1; // [R4]
        end
        tickPending_nxt = reachZero && ctrl_r.tickIntEn; // [R11]
        // Counter holds no defined value until software first writes it
        cntKnown_nxt = cntKnown_r || wrCurrent;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r        <= CTRL_RESET; // [R9]
            zeroFlag_r    <= CSR_RESET[BIT_ZERO_FLAG];
            tickPending_r <= 1'b0;
            cntKnown_r    <= 1'b0;
        end else begin
            ctrl_r        <= ctrl_nxt;
            zeroFlag_r    <= zeroFlag_nxt;
            tickPending_r <= tickPending_nxt;
            cntKnown_r    <= cntKnown_nxt;
        end
    end

    // ************************************************************
    // Counter and reload
    // ************************************************************
    always_comb begin
        reload_nxt = wrReload ? pwdata[CNT_W-1:0] : reload_r;
        current_nxt = current_r;
        if (wrCurrent) begin
            current_nxt = CNT_ZERO; // [R1]
        end else if (countTick) begin
            if (current_r == CNT_ZERO) begin
                current_nxt = reload_r; // [R3] [R8]
            end else begin
                current_nxt = current_r - CNT_ONE; // [R2]
            end
        end
    end

    // No reset here: software must program both before use
    always_ff @(posedge clk) begin
        current_r <= current_nxt; // [R6]
        reload_r  <= reload_nxt;
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign tickPending = tickPending_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_write_clears;
        wrCurrent |=> (current_r == CNT_ZERO) && !zeroFlag_r;
    endproperty
    a_write_clears: assert property (p_write_clears) else $error("current write not cleared"); // [R1]

    property p_decrement;
        countTick && !wrCurrent && (current_r != CNT_ZERO) |=> current_r == $past(current_r) - CNT_ONE;
    endproperty
    a_decrement: assert property (p_decrement) else $error("counter did not decrement"); // [R2]

    property p_reload;
        countTick && !wrCurrent && (current_r == CNT_ZERO) |=> current_r == $past(reload_r);
    endproperty
    a_reload: assert property (p_reload) else $error("reload not taken at zero"); // [R3]

    property p_flag_set;
        reachZero |=> zeroFlag_r && (current_r == CNT_ZERO);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("zero flag not set"); // [R4]

    property p_read_clear;
        rdCsr && prdata_r[BIT_ZERO_FLAG] && !reachZero |=> !zeroFlag_r;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear flag"); // [R5]

    property p_hold_zero;
        countTick && !wrCurrent && (current_r == CNT_ZERO) && (reload_r == CNT_ZERO)
            ##1 !wrCurrent |=> current_r == CNT_ZERO;
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("zero reload did not hold"); // [R8]

    property p_reload_read;
        setupPhase && !pwrite && (sel == SEL_RELOAD_VALUE)
            |=> pready_r && (prdata_r == DATA_W'($past(reload_r))) ##1 !pready_r;
    endproperty
    a_reload_read: assert property (p_reload_read) else $error("reload readback wrong"); // [R9]

    property p_stopped;
        cntKnown_r && !ctrl_r.enable && !wrCurrent |=> $stable(current_r);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while disabled"); // [R10]

    property p_pend;
        tickPending_r |-> $past(reachZero) && $past(ctrl_r.tickIntEn) && !$past(wrCurrent);
    endproperty
    a_pend: assert property (p_pend) else $error("pend without count to zero"); // [R11]

    property p_ext_wait;
        ctrl_r.enable && !ctrl_r.clockSel && !refTick && !wrCurrent |=> $stable(current_r);
    endproperty
    a_ext_wait: assert property (p_ext_wait) else $error("counted without reference tick"); // [R12]

    property p_flag_read;
        setupPhase && !pwrite && (sel == SEL_CONTROL_STATUS)
            |=> prdata_r[BIT_ZERO_FLAG] == $past(zeroFlag_r);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag readback wrong"); // [R13]

    c_reach_zero: cover property (reachZero && ctrl_r.tickIntEn);
    c_read_clear: cover property (rdCsr && prdata_r[BIT_ZERO_FLAG]);
    c_ext_count:  cover property (countTick && !ctrl_r.clockSel);
    c_bad_addr:   cover property (pslverr_r);
endmodule
`default_nettype wire

/* File: sim/system_tick_timer_bench.sv */
// Self-checking bench for the core tick timer
`timescale 1ns/1ps
`default_nettype none
module system_tick_timer_bench
    import tick_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              refClkPin = 1'b0;
    logic              tickPending;
    int                errors = 0;
    int                check_count = 0;
    int                cycle = 0;
    int                lastPend = 0;
    int                period = 0;
    int                pendCount = 0;
    logic [DATA_W-1:0] rd;
    logic              er;
    logic [DATA_W-1:0] keep;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              err;
    } row_s;

    // Reserved bits must read back as zero, unmapped places answer with an error
    row_s rows [9] = '{
        '{1'b1, OFS_RELOAD_VALUE, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
        '{1'b0, OFS_RELOAD_VALUE, 32'h0000_0000, 32'h00FF_FFFF, 1'b0},
        '{1'b1, OFS_RELOAD_VALUE, 32'hA5A5_A5A5, 32'h0000_0000, 1'b0},
        '{1'b0, OFS_RELOAD_VALUE, 32'h0000_0000, 32'h00A5_A5A5, 1'b0},
        '{1'b1, OFS_CONTROL_STATUS, 32'hFFFF_FFF8, 32'h0000_0000, 1'b0},
        '{1'b0, OFS_CONTROL_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, 12'h01C, 32'h0000_0001, 32'h0000_0000, 1'b1},
        '{1'b0, 12'h000, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b0, OFS_RELOAD_VALUE, 32'h0000_0000, 32'h00A5_A5A5, 1'b0}
    };

    system_tick_timer i_dut (
        .clk         (clk),
        .reset_n     (reset_n),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .refClkPin   (refClkPin),
        .tickPending (tickPending)
    );

    always #12.5 clk = ~clk;

    // Pend pulses are counted and spaced to see the count period
    always @(posedge clk) begin
        cycle <= cycle + 1;
        if (tickPending === 1'b1) begin
            pendCount <= pendCount + 1;
            period    <= cycle - lastPend;
            lastPend  <= cycle;
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One idle edge first, so psel never changes twice in one time step
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // No cycle limit here: a slave that never answers is caught by the watchdog
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // Pin edge needs a few synchroniser cycles before the tick lands
    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge clk);
            refClkPin <= 1'b1;
            repeat (4) @(posedge clk);
            refClkPin <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(25 * 6000);
        errors++;
        wrap_up();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk);
        check({31'h0, pready | tickPending}, 32'h0000_0000);
        reset_n <= 1'b1;
        rdchk(OFS_CONTROL_STATUS, CSR_RESET);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            check({31'h0, er}, {31'h0, rows[i].err});
            if (!rows[i].wr) begin
                check(rd, rows[i].rdata);
            end
        end
        // External reference clock, reload two
        apb(1'b1, OFS_RELOAD_VALUE, 32'h0000_0002);
        apb(1'b1, OFS_CURRENT_VALUE, 32'h0000_0000);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h0000_0003);
        pulse(2);
        rdchk(OFS_CURRENT_VALUE, 32'h0000_0001);
        pulse(1);
        check(pendCount, 1);
        rdchk(OFS_CONTROL_STATUS, 32'h0001_0003);
        rdchk(OFS_CONTROL_STATUS, 32'h0000_0003);
        pulse(1);
        rdchk(OFS_CURRENT_VALUE, 32'h0000_0002);
        pulse(2);
        apb(1'b1, OFS_CURRENT_VALUE, 32'h00AB_CDEF);
        rdchk(OFS_CURRENT_VALUE, 32'h0000_0000);
        rdchk(OFS_CONTROL_STATUS, 32'h0000_0003);
        check(pendCount, 2);
        // Exception enable off: flag still sets, no pend
        apb(1'b1, OFS_CONTROL_STATUS, 32'h0000_0001);
        apb(1'b1, OFS_RELOAD_VALUE, 32'h0000_0001);
        pulse(2);
        check(pendCount, 2);
        rdchk(OFS_CONTROL_STATUS, 32'h0001_0001);
        // Reload zero parks the counter
        apb(1'b1, OFS_RELOAD_VALUE, 32'h0000_0000);
        pulse(2);
        rdchk(OFS_CURRENT_VALUE, 32'h0000_0000);
        // Disabled counter ignores ticks
        apb(1'b1, OFS_RELOAD_VALUE, 32'h0000_0005);
        pulse(1);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h0000_0000);
        pulse(1);
        rdchk(OFS_CURRENT_VALUE, 32'h0000_0005);
        // Core clock: one pend every reload plus one cycles
        apb(1'b1, OFS_RELOAD_VALUE, 32'h0000_0003);
        apb(1'b1, OFS_CURRENT_VALUE, 32'h0000_0000);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h0000_0007);
        repeat (30) @(posedge clk);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h0000_0004);
        check(period, 4);
        check({31'h0, pendCount > 6}, 32'h0000_0001);
        apb(1'b0, OFS_CURRENT_VALUE, 32'h0000_0000);
        keep = rd;
        repeat (10) @(posedge clk);
        rdchk(OFS_CURRENT_VALUE, keep);
        // Reset with the counter stopped: the flag left set by the core clock run must clear
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, pready | pslverr | tickPending}, 32'h0000_0000);
        reset_n <= 1'b1;
        rdchk(OFS_CONTROL_STATUS, CSR_RESET);
        wrap_up();
    end
endmodule
`default_nettype wire
